// ### rtl/curdet_pkg.sv
/*
  Constants, register map and state types for the output current level
  detect block. Assumes one 200 MHz clock and currents in tenths of a
  percent of rated drive current.
*/
package curdet_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS  = 5;
  localparam int MS_NS          = 1000000;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W       = 18;

  // timing figures in milliseconds
  localparam int MIN_QUAL_MS = 50;
  localparam int HOLD_MS     = 100;
  localparam int ZL_SHORT_MS = 40;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CUR_W  = 12;
  localparam int THR_W  = 11;
  localparam int OLP_W  = 14;
  localparam int ZLP_W  = 10;
  localparam int HOLD_W = 7;
  localparam int TERM_N = 4;
  localparam int SEL_W  = 2;
  localparam int SELV_W = TERM_N * SEL_W;
  localparam int IRQ_W  = 2;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  // register offsets (byte addresses)
  localparam addr_t ADDR_OL_THR   = 8'h00;
  localparam addr_t ADDR_OL_PER   = 8'h04;
  localparam addr_t ADDR_ZL_THR   = 8'h08;
  localparam addr_t ADDR_ZL_PER   = 8'h0C;
  localparam addr_t ADDR_TERM_SEL = 8'h10;
  localparam addr_t ADDR_STATUS   = 8'h14;
  localparam addr_t ADDR_INT_STAT = 8'h18;
  localparam addr_t ADDR_INT_MASK = 8'h1C;

  // reset values and limits, tenths of percent or milliseconds
  localparam logic [THR_W-1:0] OL_THR_RST = 11'h5DC;
  localparam logic [THR_W-1:0] ZL_THR_RST = 11'h032;
  localparam logic [THR_W-1:0] THR_MAX    = 11'h7D0;
  localparam logic [OLP_W-1:0] OL_PER_RST = 14'h0000;
  localparam logic [OLP_W-1:0] OL_PER_MAX = 14'h2710;
  localparam logic [ZLP_W-1:0] ZL_PER_RST = 10'h1F4;
  localparam logic [ZLP_W-1:0] ZL_PER_MAX = 10'h3E8;

  // terminal function codes
  localparam logic [SEL_W-1:0] SEL_NONE = 2'h0;
  localparam logic [SEL_W-1:0] SEL_OVER = 2'h1;
  localparam logic [SEL_W-1:0] SEL_ZERO = 2'h2;
  localparam logic [SELV_W-1:0] TERM_SEL_RST = 8'h00;

  // status and interrupt bit positions
  localparam int BIT_OVER = 0;
  localparam int BIT_ZERO = 1;
  localparam int BIT_RUN  = 2;

  typedef struct packed {
    logic [OLP_W-1:0]  cnt;
    logic [HOLD_W-1:0] hold;
    logic              flag;
    logic              setPulse;
  } qual_s;

  typedef struct packed {
    logic [TERM_N-1:0] oe;
  } term_s;

endpackage

// ### rtl/qualify_timer.sv
/*
  Qualification and hold timer for one current level flag.
  Assumes msTick is a one-cycle pulse once per millisecond and that cond
  already includes the running condition.
*/
`timescale 1ns/1ps
`default_nettype none
module qualify_timer
  import curdet_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // timing
  input  wire logic                     msTick,
  input  wire logic [curdet_pkg::OLP_W-1:0] effPeriod,
  input  wire logic                     holdFromSet,
  // compare
  input  wire logic                     cond,
  // result
  output logic                          flag,
  output logic                          setPulse
);
  import curdet_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_TICKS = HOLD_W'(HOLD_MS);

  qual_s cur_ff;
  qual_s nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.setPulse = 1'b0;
    if (!cur_ff.flag) begin
      if (!cond) begin
        nxt_cur.cnt = '0;
      end else if (cur_ff.cnt >= effPeriod) begin
        nxt_cur.flag     = 1'b1;
        nxt_cur.setPulse = 1'b1;
        nxt_cur.hold     = holdFromSet ? HOLD_TICKS : '0;
      end else if (msTick) begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end
    end else begin
      // zero flag reloads while current is low so the hold starts on release
      if (cond && !holdFromSet) begin
        nxt_cur.hold = HOLD_TICKS;
      end else if (msTick && cur_ff.hold != '0) begin
        nxt_cur.hold = cur_ff.hold - 1'b1;
      end
      if (!cond && cur_ff.hold == '0) begin
        nxt_cur.flag = 1'b0;
        nxt_cur.cnt  = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign flag     = cur_ff.flag;
  assign setPulse = cur_ff.setPulse;

endmodule
`default_nettype wire

// ### rtl/terminal_select.sv
/*
  Open-collector output terminal function routing.
  Assumes flags come from flip-flops on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module terminal_select
  import curdet_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // routing
  input  wire logic [curdet_pkg::SELV_W-1:0] termSel,
  input  wire logic                          overFlag,
  input  wire logic                          zeroFlag,
  // open-collector terminals
  output logic      [curdet_pkg::TERM_N-1:0] termOut,
  output logic      [curdet_pkg::TERM_N-1:0] termOe
);
  import curdet_pkg::*;

  term_s             cur_ff;
  term_s             nxt_cur;
  logic [TERM_N-1:0] selOn;

  genvar gi;
  generate
    for (gi = 0; gi < TERM_N; gi++) begin : g_term
      assign selOn[gi] =
        (termSel[gi*SEL_W +: SEL_W] == SEL_OVER && overFlag) ||
        (termSel[gi*SEL_W +: SEL_W] == SEL_ZERO && zeroFlag);
    end
  endgenerate

  always_comb begin
    nxt_cur    = cur_ff;
    nxt_cur.oe = selOn;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // an active terminal sinks current: it pulls low while enabled
  assign termOut = '0;
  assign termOe  = cur_ff.oe;

endmodule
`default_nettype wire

// ### rtl/output_current_level_detect.sv
/*
  Output current level detect: over-level and zero-current flags with
  qualification and hold timing, register port, interrupt and terminal
  routing. Assumes current and running come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module output_current_level_detect
  import curdet_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = curdet_pkg::CYC_PER_MS_DEF
)
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // drive state
  input  wire logic [curdet_pkg::CUR_W-1:0]  currentMeas,
  input  wire logic                          running,
  // register port
  input  wire logic [curdet_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [curdet_pkg::DATA_W-1:0] regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [curdet_pkg::DATA_W-1:0] regRdData,
  // interrupt
  output logic                               irq,
  // open-collector terminals
  output logic      [curdet_pkg::TERM_N-1:0] termOut,
  output logic      [curdet_pkg::TERM_N-1:0] termOe
);
  import curdet_pkg::*;

  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(CYC_PER_MS - 1);
  localparam logic [OLP_W-1:0] MIN_QUAL = OLP_W'(MIN_QUAL_MS);
  localparam logic [ZLP_W-1:0] ZL_SHORT = ZLP_W'(ZL_SHORT_MS);

  typedef struct packed {
    logic [THR_W-1:0]    olThr;
    logic [OLP_W-1:0]    olPer;
    logic [THR_W-1:0]    zlThr;
    logic [ZLP_W-1:0]    zlPer;
    logic [SELV_W-1:0]   termSel;
    logic [IRQ_W-1:0]    intStat;
    logic [IRQ_W-1:0]    intMask;
    logic [DATA_W-1:0]   rdData;
    logic [MS_CNT_W-1:0] msCnt;
    logic                msTick;
    logic                olCond;
    logic                zlCond;
    logic                irq;
  } top_s;

  top_s cur_ff;
  top_s nxt_cur;

  logic             overFlag;
  logic             zeroFlag;
  logic             overSet;
  logic             zeroSet;
  logic [OLP_W-1:0] olEff;
  logic [OLP_W-1:0] zlEff;

  // clamp a written value to the setting's upper limit
  function automatic logic [OLP_W-1:0] clampVal(
    input logic [DATA_W-1:0] val,
    input logic [OLP_W-1:0]  lim
  );
    logic [OLP_W-1:0] res;
    res = lim;
    if (val <= DATA_W'(lim)) begin
      res = val[OLP_W-1:0];
    end
    return res;
  endfunction

  // effective qualification periods in ms ticks
  always_comb begin
    olEff = cur_ff.olPer;
    if (cur_ff.olPer == '0) begin
      olEff = MIN_QUAL;
    end
    zlEff = OLP_W'(cur_ff.zlPer);
    if (cur_ff.zlPer <= ZL_SHORT) begin
      zlEff = MIN_QUAL;
    end
  end

  always_comb begin
    nxt_cur = cur_ff;

    // millisecond tick shared by both timers
    nxt_cur.msTick = 1'b0;
    if (cur_ff.msCnt == MS_LAST) begin
      nxt_cur.msCnt  = '0;
      nxt_cur.msTick = 1'b1;
    end else begin
      nxt_cur.msCnt = cur_ff.msCnt + 1'b1;
    end

    // compares are registered to keep the threshold path short;
    // running is the only gate on either compare
    nxt_cur.olCond = running &&
      (currentMeas > CUR_W'(cur_ff.olThr));
    nxt_cur.zlCond = running &&
      (currentMeas < CUR_W'(cur_ff.zlThr));

    // register writes, values clamped to their documented ranges
    if (regWr) begin
      unique case (regAddr)
        ADDR_OL_THR: begin
          nxt_cur.olThr = THR_W'(clampVal(regWrData,
                                          OLP_W'(THR_MAX)));
        end
        ADDR_OL_PER: begin
          nxt_cur.olPer = clampVal(regWrData, OL_PER_MAX);
        end
        ADDR_ZL_THR: begin
          nxt_cur.zlThr = THR_W'(clampVal(regWrData,
                                          OLP_W'(THR_MAX)));
        end
        ADDR_ZL_PER: begin
          nxt_cur.zlPer = ZLP_W'(clampVal(regWrData,
                                          OLP_W'(ZL_PER_MAX)));
        end
        ADDR_TERM_SEL: begin
          nxt_cur.termSel = regWrData[SELV_W-1:0];
        end
        ADDR_INT_STAT: begin
          nxt_cur.intStat = cur_ff.intStat & ~regWrData[IRQ_W-1:0];
        end
        ADDR_INT_MASK: begin
          nxt_cur.intMask = regWrData[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // a flag rising in the clearing cycle still sets its bit
    if (overSet) begin
      nxt_cur.intStat[BIT_OVER] = 1'b1;
    end
    if (zeroSet) begin
      nxt_cur.intStat[BIT_ZERO] = 1'b1;
    end
    nxt_cur.irq = |(nxt_cur.intStat & nxt_cur.intMask);

    // read data stand only in the cycle after the strobe
    nxt_cur.rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        ADDR_OL_THR: begin
          nxt_cur.rdData = DATA_W'(cur_ff.olThr);
        end
        ADDR_OL_PER: begin
          nxt_cur.rdData = DATA_W'(cur_ff.olPer);
        end
        ADDR_ZL_THR: begin
          nxt_cur.rdData = DATA_W'(cur_ff.zlThr);
        end
        ADDR_ZL_PER: begin
          nxt_cur.rdData = DATA_W'(cur_ff.zlPer);
        end
        ADDR_TERM_SEL: begin
          nxt_cur.rdData = DATA_W'(cur_ff.termSel);
        end
        ADDR_STATUS: begin
          nxt_cur.rdData[BIT_OVER] = overFlag;
          nxt_cur.rdData[BIT_ZERO] = zeroFlag;
          nxt_cur.rdData[BIT_RUN]  = running;
        end
        ADDR_INT_STAT: begin
          nxt_cur.rdData = DATA_W'(cur_ff.intStat);
        end
        ADDR_INT_MASK: begin
          nxt_cur.rdData = DATA_W'(cur_ff.intMask);
        end
        default: begin
          nxt_cur.rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff         <= '0;
      cur_ff.olThr   <= OL_THR_RST;
      cur_ff.olPer   <= OL_PER_RST;
      cur_ff.zlThr   <= ZL_THR_RST;
      cur_ff.zlPer   <= ZL_PER_RST;
      cur_ff.termSel <= TERM_SEL_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // over flag: hold counted from the moment it sets
  qualify_timer u_over (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .msTick      (cur_ff.msTick),
    .effPeriod   (olEff),
    .holdFromSet (1'b1),
    .cond        (cur_ff.olCond),
    .flag        (overFlag),
    .setPulse    (overSet)
  );

  // zero flag: hold counted from the moment current rises again or running drops
  qualify_timer u_zero (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .msTick      (cur_ff.msTick),
    .effPeriod   (zlEff),
    .holdFromSet (1'b0),
    .cond        (cur_ff.zlCond),
    .flag        (zeroFlag),
    .setPulse    (zeroSet)
  );

  terminal_select u_term (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .termSel  (cur_ff.termSel),
    .overFlag (overFlag),
    .zeroFlag (zeroFlag),
    .termOut  (termOut),
    .termOe   (termOe)
  );

  assign regRdData = cur_ff.rdData;
  assign irq       = cur_ff.irq;

endmodule
`default_nettype wire

// ### test/curdet_properties.sv
/*
  Port checker for output_current_level_detect.
  Assumes one clock domain and sees only the ports of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module curdet_properties
  import curdet_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = 4
)
(
  // clock and reset
  input wire logic                          clk,
  input wire logic                          sys_rst,
  // watched ports
  input wire logic                          running,
  input wire logic [curdet_pkg::ADDR_W-1:0] regAddr,
  input wire logic [curdet_pkg::DATA_W-1:0] regWrData,
  input wire logic                          regWr,
  input wire logic                          regRd,
  input wire logic [curdet_pkg::DATA_W-1:0] regRdData,
  input wire logic                          irq,
  input wire logic [curdet_pkg::TERM_N-1:0] termOut,
  input wire logic [curdet_pkg::TERM_N-1:0] termOe
);
  localparam int HOLD_CYC = (HOLD_MS - 1) * CYC_PER_MS;
  localparam int STOP_CYC = (HOLD_MS + 3) * CYC_PER_MS;
  // termOe registers one cycle after the routing register, while irq
  // registers in the same cycle as the mask, so only the routing shadow lags to match
  logic [SELV_W-1:0] sel_ff, selDly_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic [15:0]       onOver_ff, onZero_ff, stop_ff;
  logic [TERM_N-1:0] offMask;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sel_ff, selDly_ff} <= '0;
      mask_ff <= '0;
      {onOver_ff, onZero_ff, stop_ff} <= '0;
    end else begin
      if (regWr && regAddr == ADDR_TERM_SEL) begin
        sel_ff <= regWrData[SELV_W-1:0];
      end
      if (regWr && regAddr == ADDR_INT_MASK) begin
        mask_ff <= regWrData[IRQ_W-1:0];
      end
      selDly_ff   <= sel_ff;
      onOver_ff   <= termOe[0] ? onOver_ff + 16'h1 : 16'h0;
      onZero_ff   <= termOe[1] ? onZero_ff + 16'h1 : 16'h0;
      stop_ff     <= running ? 16'h0 : stop_ff + 16'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < TERM_N; i++) begin
      offMask[i] = selDly_ff[2*i +: 2] != SEL_OVER &&
                   selDly_ff[2*i +: 2] != SEL_ZERO;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_over_fall;
    selDly_ff[1:0] == SEL_OVER && $fell(termOe[0]);
  endsequence
  sequence s_zero_fall;
    selDly_ff[3:2] == SEL_ZERO && $fell(termOe[1]);
  endsequence
  sequence s_unmapped_rd;
    regRd && regAddr >= 8'h20;
  endsequence

  property p_over_hold; s_over_fall |-> onOver_ff >= HOLD_CYC; endproperty
  a_over_hold: assert property (p_over_hold)
    else $error("over flag released early");
  property p_zero_hold; s_zero_fall |-> onZero_ff >= HOLD_CYC; endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("zero flag released early");
  property p_sel_none; (termOe & offMask) == '0; endproperty
  a_sel_none: assert property (p_sel_none)
    else $error("unassigned terminal active");
  property p_term_out; termOut == '0; endproperty
  a_term_out: assert property (p_term_out)
    else $error("terminal drives high");
  property p_stopped; stop_ff > STOP_CYC |-> termOe == '0; endproperty
  a_stopped: assert property (p_stopped)
    else $error("flag stays on after stop");
  property p_rd_idle; !$past(regRd) |-> regRdData == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_unmapped; s_unmapped_rd |=> regRdData == '0; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_mask_irq; mask_ff == '0 |-> !irq; endproperty
  a_mask_irq: assert property (p_mask_irq)
    else $error("irq with all masked");
endmodule

bind output_current_level_detect curdet_properties #(
  .CYC_PER_MS(CYC_PER_MS)
) u_props (
  .clk(clk), .sys_rst(sys_rst), .running(running), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .irq(irq), .termOut(termOut), .termOe(termOe)
);
`default_nettype wire

// ### test/brake_model.sv
/*
  Far side: pull-ups on the open-collector terminals and a brake.
  Assumes terminal 1 is assigned the zero-current flag.
*/
`timescale 1ns/1ps
`default_nettype none
module brake_model
  import curdet_pkg::*;
(
  // terminals from the block
  input  wire logic [curdet_pkg::TERM_N-1:0] termOut,
  input  wire logic [curdet_pkg::TERM_N-1:0] termOe,
  // observed levels
  output logic      [curdet_pkg::TERM_N-1:0] pinLevel,
  output logic                               brakeClosed
);
  // a released terminal is pulled high, never left at its last level
  always_comb begin
    for (int i = 0; i < TERM_N; i++) begin
      pinLevel[i] = termOe[i] ? termOut[i] : 1'b1;
    end
    brakeClosed = !pinLevel[1];
  end
endmodule
`default_nettype wire

// ### test/output_current_level_detect_tb_top.sv
/*
  Bench for output_current_level_detect with a brake model.
  Assumes CYC_PER_MS of 4, so one millisecond is four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module output_current_level_detect_tb_top;
  import curdet_pkg::*;
  localparam int CPM   = 4;
  localparam int LIMIT = 12000;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [CUR_W-1:0]  currentMeas = '0;
  logic              running = 1'b0;
  addr_t             regAddr = '0;
  data_t             regWrData = '0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  data_t             regRdData;
  logic              irq;
  logic [TERM_N-1:0] termOut, termOe, pinLevel;
  logic              brakeClosed;
  int                mismatches = 0;
  int                nCompared = 0;
  int                cycles = 0;

  always #2.5 clk = ~clk;

  output_current_level_detect #(.CYC_PER_MS(CPM)) dut (
    .clk(clk), .sys_rst(sys_rst), .currentMeas(currentMeas),
    .running(running), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
    .termOut(termOut), .termOe(termOe));
  brake_model u_brake (.termOut(termOut), .termOe(termOe),
    .pinLevel(pinLevel), .brakeClosed(brakeClosed));

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string w, input data_t e, input data_t g);
    nCompared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic sig(input string w, input logic e, input logic g);
    chk(w, data_t'(e), data_t'(g));
  endtask
  task automatic wr(input addr_t a, input data_t d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdchk(input addr_t a, input data_t e, input string w);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(w, e, regRdData);
  endtask
  task automatic wait_ms(input int ms);
    repeat (ms * CPM) @(posedge clk);
  endtask
  task automatic drive(input logic r, input logic [CUR_W-1:0] c, int ms);
    @(posedge clk);
    running     <= r;
    currentMeas <= c;
    wait_ms(ms);
  endtask
  // terminal sinks low while its flag is on
  task automatic pin(input int b, input logic on, input string w);
    #1;
    sig(w, !on, pinLevel[b]);
  endtask

  task automatic test_regs;
    addr_t a [4] = '{ADDR_OL_THR, ADDR_ZL_THR, ADDR_OL_PER, ADDR_ZL_PER};
    data_t m [4] = '{32'h7D0, 32'h7D0, 32'h2710, 32'h3E8};
    rdchk(ADDR_OL_THR, 32'h5DC, "olThr");
    rdchk(ADDR_OL_PER, 32'h0, "olPer");
    rdchk(ADDR_ZL_THR, 32'h32, "zlThr");
    rdchk(ADDR_ZL_PER, 32'h1F4, "zlPer");
    rdchk(8'h20, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(a[i], m[i]);
      rdchk(a[i], m[i], "maxSetting");
      wr(a[i], 32'h0);
      rdchk(a[i], 32'h0, "minSetting");
    end
    $display("test_regs done");
  endtask

  task automatic test_over;
    wr(ADDR_OL_PER, 32'hA);
    drive(1'b1, 12'h3E8, 15);
    pin(0, 1'b0, "overAtLevel");
    drive(1'b1, 12'h3E9, 9);
    pin(0, 1'b0, "overEarly");
    wait_ms(4);
    pin(0, 1'b1, "overSet");
    sig("overIrq", 1'b1, irq);
    rdchk(ADDR_STATUS, 32'h5, "status");
    rdchk(ADDR_INT_STAT, 32'h1, "intStat");
    drive(1'b1, 12'h1F4, 92);
    pin(0, 1'b1, "overHold");
    wait_ms(14);
    pin(0, 1'b0, "overOff");
    wr(ADDR_INT_STAT, 32'h1);
    rdchk(ADDR_INT_STAT, 32'h0, "intClr");
    sig("irqClr", 1'b0, irq);
    $display("test_over done");
  endtask

  task automatic test_restart;
    wr(ADDR_OL_PER, 32'h0);
    wr(ADDR_INT_MASK, 32'h2);
    drive(1'b1, 12'h3E9, 40);
    pin(0, 1'b0, "overMinEarly");
    drive(1'b1, 12'h1F4, 2);
    drive(1'b1, 12'h3E9, 40);
    pin(0, 1'b0, "overRestart");
    wait_ms(14);
    pin(0, 1'b1, "overMin");
    sig("irqMasked", 1'b0, irq);
    rdchk(ADDR_INT_STAT, 32'h1, "intMasked");
    wr(ADDR_INT_STAT, 32'h3);
    wr(ADDR_INT_MASK, 32'h3);
    drive(1'b1, 12'h1F4, 106);
    pin(0, 1'b0, "overOff2");
    $display("test_restart done");
  endtask

  task automatic test_zero;
    wr(ADDR_ZL_PER, 32'h28);
    drive(1'b1, 12'h032, 55);
    pin(1, 1'b0, "zeroAtLevel");
    drive(1'b1, 12'h031, 48);
    pin(1, 1'b0, "zeroEarly");
    wait_ms(6);
    pin(1, 1'b1, "zeroSet");
    pin(0, 1'b0, "termOver");
    pin(2, 1'b0, "termNone");
    pin(3, 1'b0, "termSpare");
    sig("brake", 1'b1, brakeClosed);
    sig("zeroIrq", 1'b1, irq);
    drive(1'b1, 12'h1F4, 94);
    pin(1, 1'b1, "zeroHold");
    wait_ms(10);
    pin(1, 1'b0, "zeroOff");
    wr(ADDR_INT_STAT, 32'h2);
    $display("test_zero done");
  endtask

  task automatic test_stop;
    drive(1'b1, 12'h000, 55);
    pin(1, 1'b1, "zeroSetStop");
    drive(1'b0, 12'h000, 106);
    pin(1, 1'b0, "zeroStopOff");
    wait_ms(60);
    pin(1, 1'b0, "zeroStopped");
    rdchk(ADDR_STATUS, 32'h0, "statusStop");
    $display("test_stop done");
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    test_regs();
    wr(ADDR_TERM_SEL, 32'hC9);
    wr(ADDR_INT_MASK, 32'h3);
    wr(ADDR_OL_THR, 32'h3E8);
    wr(ADDR_ZL_THR, 32'h32);
    rdchk(ADDR_TERM_SEL, 32'hC9, "termSel");
    test_over();
    test_restart();
    test_zero();
    test_stop();
    report_and_stop();
  end
endmodule
`default_nettype wire
